// File: logic/prss_top.sv
// How it works
// - 8-bit pipeline register loads on pipeline edge
// - Mode low: pipeline loads from data port
// - Mode high: pipeline loads from shadow register
// - Shadow changes only on shadow clock edge
// - Mode low: shift toward bit 7, data off
// - Scan out: bit 7, or scan in when mode high
// - Mode high, scan low: capture output port
// - Mode and scan high: hold, drive data port
// - Hold by blocking shadow edge, not recirculating
// - Output port drives pipeline when enable low
// - Shift and pipeline load may coincide freely
`include "prss_defs.svh"

module prss_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic pipeClock,
	input wire logic shadowClock,
	input wire logic mode,
	input wire logic scanIn,
	input wire logic outPortEnableN,
	input wire prss_pkg::prss_byte_t dataPortIn,
	input wire prss_pkg::prss_byte_t outPortIn,
	output prss_pkg::prss_byte_t dataPortOut,
	output logic dataPortOeN,
	output prss_pkg::prss_byte_t outPortOut,
	output logic outPortOeN,
	output logic scanOut
);

	logic [`PRSS_CLOCK_PINS-1:0] clockLevel;
	logic [`PRSS_CLOCK_PINS-1:0] clockRise;
	logic [`PRSS_CTRL_PINS-1:0] ctrlLevel;
	prss_pkg::prss_byte_t dataSync;
	prss_pkg::prss_byte_t outSync;
	prss_pkg::prss_byte_t pipeBits;
	prss_pkg::prss_byte_t shadowBits;
	prss_pkg::prss_byte_t next_pipe;
	prss_pkg::prss_shop_t shadowOp;
	wire logic pipeRise;
	wire logic shadowRise;
	wire logic modeSync;
	wire logic scanSync;
	wire logic outEnableSyncN;
	wire logic shadowLoad;
	wire logic dataDrive;
	wire logic next_scanOut;

	// Pins enter the core clock through two flip-flops before use
	prss_sync #(
		.WIDTH(`PRSS_CLOCK_PINS)
	) u_clock_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pinIn({shadowClock, pipeClock}),
		.level(clockLevel),
		.rise(clockRise)
	);

	prss_sync #(
		.WIDTH(`PRSS_CTRL_PINS)
	) u_ctrl_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pinIn({outPortEnableN, scanIn, mode}),
		.level(ctrlLevel),
		.rise()
	);

	prss_sync #(
		.WIDTH(2 * `PRSS_WIDTH)
	) u_data_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pinIn({outPortIn, dataPortIn}),
		.level({outSync, dataSync}),
		.rise()
	);

	assign pipeRise = clockRise[0];
	assign shadowRise = clockRise[1];
	assign modeSync = ctrlLevel[0];
	assign scanSync = ctrlLevel[1];
	assign outEnableSyncN = ctrlLevel[2];

	assign shadowOp = prss_pkg::prss_shadow_op(modeSync, scanSync);
	// Hold swallows the shadow edge instead of reloading the same value
	assign shadowLoad = shadowRise && (shadowOp != prss_pkg::PRSS_SH_HOLD);
	assign dataDrive = (shadowOp == prss_pkg::PRSS_SH_HOLD);
	assign next_pipe = modeSync ? shadowBits : dataSync;
	assign next_scanOut = modeSync ? scanSync : shadowBits[`PRSS_SCAN_MSB];

	prss_shadow u_shadow (
		.core_clk(core_clk),
		.shadowLoad(shadowLoad),
		.shadowOp(shadowOp),
		.scanBit(scanSync),
		.parallelIn(outSync),
		.shadowBits(shadowBits)
	);

	// Pipeline has no reset and ignores the shadow clock entirely
	always_ff @(posedge core_clk) begin
		if (pipeRise) begin
			pipeBits <= next_pipe;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			outPortOut <= '0;
			outPortOeN <= 1'b1;
		end else begin
			outPortOut <= pipeBits;
			outPortOeN <= outEnableSyncN;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dataPortOut <= '0;
			dataPortOeN <= 1'b1;
			scanOut <= 1'b0;
		end else begin
			dataPortOut <= shadowBits;
			dataPortOeN <= !dataDrive;
			scanOut <= next_scanOut;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (sys_rst);

	sequence s_shift_edge;
		shadowRise && !modeSync;
	endsequence

	a_pipe_from_data: assert property (pipeRise && !modeSync |=> pipeBits == $past(dataSync))
		else $error("pipeline did not load the data port");

	a_pipe_from_shadow: assert property (pipeRise && modeSync |=> pipeBits == $past(shadowBits))
		else $error("pipeline did not load the shadow register");

	a_pipe_only_edge: assert property (!pipeRise |=> pipeBits === $past(pipeBits))
		else $error("pipeline changed without a pipeline clock edge");

	a_shadow_only_edge: assert property (!shadowRise |=> shadowBits === $past(shadowBits))
		else $error("shadow changed without a shadow clock edge");

	// Case equality: unloaded shadow bits may still be unknown during the first shifts
	a_shadow_shift: assert property (s_shift_edge |=>
		shadowBits === {$past(shadowBits[`PRSS_SCAN_MSB-1:`PRSS_SCAN_LSB]), $past(scanSync)})
		else $error("shadow shift result wrong");

	a_shadow_capture: assert property (shadowRise && modeSync && !scanSync |=>
		shadowBits == $past(outSync))
		else $error("shadow did not capture the output port");

	a_shadow_hold: assert property (modeSync && scanSync |-> !shadowLoad ##1
		shadowBits === $past(shadowBits))
		else $error("shadow moved during hold");

	a_scan_out_sel: assert property (1'b1 |=>
		scanOut === ($past(modeSync) ? $past(scanSync) : $past(shadowBits[`PRSS_SCAN_MSB])))
		else $error("scan output selects the wrong source");

	a_data_drive: assert property (modeSync && scanSync |=>
		!dataPortOeN && dataPortOut == $past(shadowBits))
		else $error("data port not driven with shadow contents");

	a_data_quiet: assert property (!(modeSync && scanSync) |=> dataPortOeN)
		else $error("data port driven outside hold");

	a_out_port_drive: assert property (!outEnableSyncN |=>
		!outPortOeN && outPortOut == $past(pipeBits))
		else $error("output port does not present the pipeline");

	a_out_port_float: assert property (outEnableSyncN |=> outPortOeN)
		else $error("output port driven while disabled");

	a_both_edges: assert property (pipeRise && shadowRise && !modeSync |=>
		pipeBits == $past(dataSync)
		&& shadowBits[`PRSS_SCAN_LSB] === $past(scanSync))
		else $error("simultaneous shift and load interfered");

	c_shift: cover property (s_shift_edge ##1 !shadowRise [*3] ##1 s_shift_edge);
	c_capture: cover property (shadowRise && modeSync && !scanSync);
	c_write_store: cover property (s_shift_edge ##[1:200] (modeSync && scanSync && !dataPortOeN));
	c_both_edges: cover property (pipeRise && shadowRise && !modeSync);

endmodule : prss_top

// File: logic/prss_defs.svh
`ifndef PRSS_DEFS_SVH
`define PRSS_DEFS_SVH

// Width of the pipeline and shadow registers and of both ports
`define PRSS_WIDTH 8
// Bit of the shadow register that feeds the serial output
`define PRSS_SCAN_MSB 7
// Bit of the shadow register that the serial input enters
`define PRSS_SCAN_LSB 0
// Control pins passed through one shared synchroniser: mode, scan in, output enable
`define PRSS_CTRL_PINS 3
// Clock pins sampled for edges: pipeline clock, shadow clock
`define PRSS_CLOCK_PINS 2

`endif

// File: logic/prss_pkg.sv
`include "prss_defs.svh"

package prss_pkg;

	typedef logic [`PRSS_WIDTH-1:0] prss_byte_t;

	typedef enum logic [1:0] {
		PRSS_SH_SHIFT,
		PRSS_SH_CAPTURE,
		PRSS_SH_HOLD
	} prss_shop_t;

	// Shadow operation chosen by mode and serial input
	function automatic prss_shop_t prss_shadow_op(input logic modeLvl, input logic scanLvl);
		if (!modeLvl) begin
			return PRSS_SH_SHIFT;
		end
		return scanLvl ? PRSS_SH_HOLD : PRSS_SH_CAPTURE;
	endfunction : prss_shadow_op

endpackage : prss_pkg

// File: logic/prss_sync.sv
`include "prss_defs.svh"

module prss_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] stageOne;
	logic [WIDTH-1:0] stageTwo;
	logic [WIDTH-1:0] stageThree;

	// First stage is read only by the second
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stageOne <= '0;
			stageTwo <= '0;
			stageThree <= '0;
		end else begin
			stageOne <= pinIn;
			stageTwo <= stageOne;
			stageThree <= stageTwo;
		end
	end

	assign level = stageTwo;
	assign rise = stageTwo & ~stageThree;

endmodule : prss_sync

// File: logic/prss_shadow.sv
`include "prss_defs.svh"

module prss_shadow (
	input wire logic core_clk,
	input wire logic shadowLoad,
	input wire prss_pkg::prss_shop_t shadowOp,
	input wire logic scanBit,
	input wire prss_pkg::prss_byte_t parallelIn,
	output prss_pkg::prss_byte_t shadowBits
);

	prss_pkg::prss_byte_t next_shadow;
	prss_pkg::prss_byte_t shifted;

	assign shifted = {shadowBits[`PRSS_SCAN_MSB-1:`PRSS_SCAN_LSB], scanBit};
	assign next_shadow = (shadowOp == prss_pkg::PRSS_SH_SHIFT) ? shifted : parallelIn;

	// No reset: contents are undefined until loaded; a shift edge defines only bit 0, a capture edge all bits
	always_ff @(posedge core_clk) begin
		if (shadowLoad) begin
			shadowBits <= next_shadow;
		end
	end

endmodule : prss_shadow

// File: test/prss_far_end.sv
module prss_far_end (
	input wire logic core_clk,
	input wire logic extDataDrive,
	input wire prss_pkg::prss_byte_t extData,
	input wire logic extOutDrive,
	input wire prss_pkg::prss_byte_t extOut,
	input wire prss_pkg::prss_byte_t dataPortOut,
	input wire logic dataPortOeN,
	input wire prss_pkg::prss_byte_t outPortOut,
	input wire logic outPortOeN,
	output prss_pkg::prss_byte_t dataPortIn,
	output prss_pkg::prss_byte_t outPortIn
);
	timeunit 1ns;
	timeprecision 1ps;
	prss_pkg::prss_byte_t lastData = 8'h00;
	prss_pkg::prss_byte_t lastOut = 8'h00;
	// A floating wire keeps toggling rather than showing a stale value
	assign dataPortIn = !dataPortOeN ? dataPortOut : (extDataDrive ? extData : ~lastData);
	assign outPortIn = !outPortOeN ? outPortOut : (extOutDrive ? extOut : ~lastOut);
	always @(posedge core_clk) begin
		lastData <= dataPortIn;
		lastOut <= outPortIn;
	end
endmodule : prss_far_end

// File: test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic pipeClock = 1'b0;
	logic shadowClock = 1'b0;
	logic mode = 1'b0;
	logic scanIn = 1'b0;
	logic outPortEnableN = 1'b1;
	logic extDataDrive = 1'b1;
	logic extOutDrive = 1'b0;
	logic dataPortOeN, outPortOeN, scanOut;
	prss_pkg::prss_byte_t extData = 8'h00;
	prss_pkg::prss_byte_t extOut = 8'h00;
	prss_pkg::prss_byte_t dataPortIn, outPortIn, dataPortOut, outPortOut, expShadow;
	int fails = 0;
	int check_count = 0;
	always #50 core_clk = ~core_clk;
	prss_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .pipeClock(pipeClock),
		.shadowClock(shadowClock), .mode(mode), .scanIn(scanIn),
		.outPortEnableN(outPortEnableN), .dataPortIn(dataPortIn), .outPortIn(outPortIn),
		.dataPortOut(dataPortOut), .dataPortOeN(dataPortOeN), .outPortOut(outPortOut),
		.outPortOeN(outPortOeN), .scanOut(scanOut));
	prss_far_end farEnd (.core_clk(core_clk), .extDataDrive(extDataDrive), .extData(extData),
		.extOutDrive(extOutDrive), .extOut(extOut), .dataPortOut(dataPortOut),
		.dataPortOeN(dataPortOeN), .outPortOut(outPortOut), .outPortOeN(outPortOeN),
		.dataPortIn(dataPortIn), .outPortIn(outPortIn));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	task automatic settle();
		repeat (4) @(posedge core_clk);
		#1;
	endtask : settle
	// Pins stay still for several core cycles either side of each rise
	task automatic pulse(input logic pipe, input logic shadow);
		repeat (3) @(posedge core_clk);
		#1;
		pipeClock = pipe;
		shadowClock = shadow;
		settle();
		pipeClock = 1'b0;
		shadowClock = 1'b0;
		settle();
	endtask : pulse
	task automatic shift_word(input logic [7:0] w);
		mode = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			scanIn = w[i];
			pulse(1'b0, 1'b1);
			expShadow = {expShadow[6:0], w[i]};
			check("scanOut", {7'h00, scanOut}, {7'h00, expShadow[7]});
			check("dataPortOeN", {7'h00, dataPortOeN}, 8'h01);
		end
	endtask : shift_word
	task automatic t_shift_pipe();
		shift_word(8'hA5);
		extData = 8'h3C;
		outPortEnableN = 1'b0;
		scanIn = 1'b0;
		pulse(1'b1, 1'b1);
		expShadow = {expShadow[6:0], 1'b0};
		check("outPortOut", outPortOut, 8'h3C);
		check("outPortOeN", {7'h00, outPortOeN}, 8'h00);
		check("scanOut", {7'h00, scanOut}, {7'h00, expShadow[7]});
	endtask : t_shift_pipe
	task automatic t_store_write();
		shift_word(8'h96);
		extDataDrive = 1'b0;
		mode = 1'b1;
		scanIn = 1'b1;
		settle();
		check("dataPortOeN", {7'h00, dataPortOeN}, 8'h00);
		check("dataPortOut", dataPortOut, 8'h96);
		check("scanOut", {7'h00, scanOut}, 8'h01);
		pulse(1'b0, 1'b1);
		check("dataPortOut", dataPortOut, 8'h96);
		scanIn = 1'b0;
		settle();
		check("scanOut", {7'h00, scanOut}, 8'h00);
		check("dataPortOeN", {7'h00, dataPortOeN}, 8'h01);
		extDataDrive = 1'b1;
	endtask : t_store_write
	task automatic t_pipe_from_shadow();
		extData = 8'h11;
		pulse(1'b1, 1'b0);
		check("outPortOut", outPortOut, 8'h96);
	endtask : t_pipe_from_shadow
	task automatic t_capture();
		outPortEnableN = 1'b1;
		extOutDrive = 1'b1;
		extOut = 8'h5A;
		settle();
		check("outPortOeN", {7'h00, outPortOeN}, 8'h01);
		pulse(1'b0, 1'b1);
		expShadow = 8'h5A;
		mode = 1'b0;
		settle();
		check("scanOut", {7'h00, scanOut}, 8'h00);
		shift_word(8'h00);
		check("outPortOut", outPortOut, 8'h96);
	endtask : t_capture
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		t_shift_pipe();
		t_store_write();
		t_pipe_from_shadow();
		t_capture();
		wrap_up();
	end
	initial begin
		#200us;
		fails++;
		wrap_up();
	end
endmodule : testbench
